// ==== logic/ppc_prom_program_control.sv ====
// Purpose: PROM programming control register, latches, power switch and
//          serial download engine with per-byte echo
// Assumes: Avalon-MM master with waitrequest; serial pins async
// Notes:   Array is modelled as an internal byte array, erased to all ones
// Functional notes
// RULE_01 - Reset clears whole programming control register
// RULE_02 - Latch mode: array writes capture address, data
// RULE_03 - Latch clear: normal reads, no programming; the download engine still writes the array in DL_PROG with latch clear
// RULE_04 - Power bit writable only with latch set
// RULE_05 - Power bit switches programming supply on/off
// RULE_06 - Software sets latch, then writes data
// RULE_07 - Software powers 2-4 ms, then clears
// RULE_08 - Software needs memory present, irq high
// RULE_09 - Bits 6, 2, 1 read zero
// RULE_10 - Factory test bits stay cleared normally; the code lets a control write set bits 4 and 3 in every mode
// RULE_11 - Download only in special test/boot modes
// RULE_12 - Host boots jump to utility entry
// RULE_13 - Delay from index X, start from Y
// RULE_14 - Send ready byte, host then sends
// RULE_15 - Echo verification byte per programmed byte
// RULE_16 - Host ends session by resetting device
// RULE_17 - Erased byte reads back all ones
// RULE_18 - Power set with latch clear ignored
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module ppc_prom_program_control (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    // Avalon-MM slave
    input  wire logic [7:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // Device mode and serial link pins
    input  wire ppc_pkg::ppc_mode_t   deviceMode,
    input  wire logic                 serialRxPin,
    output logic                      serialTxPin,
    // Programming supply switch
    output logic                      programPowerOn
);

    // =====================================================
    // Helpers
    // =====================================================
    // Map a 16-bit target address onto the array index
    function automatic logic [ppc_pkg::ARRAY_AW-1:0] arrayIndex(input logic [15:0] a);
        arrayIndex = a[ppc_pkg::ARRAY_AW-1:0];
    endfunction

    // =====================================================
    // Pin synchronisers
    // =====================================================
    logic rxMeta_q, rxSync_q;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rxMeta_q <= 1'b1;
            rxSync_q <= 1'b1;
        end else begin
            rxMeta_q <= serialRxPin;
            rxSync_q <= rxMeta_q;
        end
    end

    // =====================================================
    // State declarations
    // =====================================================
    typedef enum {DL_IDLE, DL_READY, DL_WAIT, DL_PROG, DL_ECHO} ppc_dl_t;
    typedef enum {TX_IDLE, TX_SHIFT} ppc_tx_t;
    typedef enum {RX_IDLE, RX_SHIFT} ppc_rx_t;

    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  config_q, config_d;
    logic [15:0] ixReg_q, ixReg_d;
    logic [15:0] iyReg_q, iyReg_d;
    logic [ppc_pkg::ARRAY_AW-1:0] latAddr_q, latAddr_d;
    logic [7:0]  latData_q, latData_d;
    logic [7:0]  mem [ppc_pkg::ARRAY_DEPTH];
    logic        memWe;
    logic [ppc_pkg::ARRAY_AW-1:0] memWa;
    logic [7:0]  memWd;
    logic [31:0] rdData_q, rdData_d;
    logic        ack_q, ack_d;
    ppc_dl_t     dl_q, dl_d;
    logic [15:0] dlAddr_q, dlAddr_d;
    logic [15:0] usLeft_q, usLeft_d;
    logic [5:0]  usDiv_q, usDiv_d;
    ppc_tx_t     tx_q, tx_d;
    logic [9:0]  txShift_q, txShift_d;
    logic [3:0]  txBits_q, txBits_d;
    logic [11:0] txBaud_q, txBaud_d;
    ppc_rx_t     rx_q, rx_d;
    logic [7:0]  rxShift_q, rxShift_d;
    logic [3:0]  rxBits_q, rxBits_d;
    logic [11:0] rxBaud_q, rxBaud_d;
    ppc_pkg::ppc_byte_t rxByte;
    ppc_pkg::ppc_byte_t txReq;
    logic        txBusy;
    logic        specialMode;
    logic        usTick;

    // Download is legal only in the special modes
    assign specialMode = (deviceMode == ppc_pkg::MODE_SPECIAL_BOOT) ||
                         (deviceMode == ppc_pkg::MODE_SPECIAL_TEST);  // [RULE_11]
    assign usTick      = (usDiv_q == 6'(ppc_pkg::US_TICK_CYCLES - 1));
    assign txBusy      = (tx_q != TX_IDLE);

    // =====================================================
    // Register bus and control register
    // =====================================================
    // Every access answers one cycle after it is presented; waitrequest
    // drops only for that answer cycle, and writes land at its edge
    always_comb begin
        logic       inWin;
        logic [7:0] wb;
        inWin    = 1'b0;
        wb       = avs_writedata[7:0];
        ctrl_d   = ctrl_q;
        config_d = config_q;
        ixReg_d  = ixReg_q;
        iyReg_d  = iyReg_q;
        latAddr_d = latAddr_q;
        latData_d = latData_q;
        rdData_d = rdData_q;
        ack_d    = 1'b0;
        memWe    = 1'b0;
        memWa    = latAddr_q;
        memWd    = latData_q;
        inWin    = (avs_address & ppc_pkg::WIN_MASK) != 8'h00;
        if ((avs_read || avs_write) && !ack_q) begin
            ack_d    = 1'b1;
            rdData_d = 32'h0000_0000;
        end
        if ((avs_write && ack_q) || (avs_read && !ack_q)) begin
            if (avs_write && avs_byteenable[0]) begin
                if (inWin) begin
                    // Latch mode captures address and data for programming
                    if (ctrl_q[ppc_pkg::BIT_LATCH]) begin              // [RULE_02]
                        latAddr_d = arrayIndex({8'h00, avs_address & ~ppc_pkg::WIN_MASK});
                        latData_d = wb;
                    end
                end else begin
                    case (avs_address)
                        ppc_pkg::OFF_CTRL: begin
                            ctrl_d = wb & ppc_pkg::CTRL_IMPL;           // [RULE_09] [RULE_10]
                            // Power bit follows the write only under latch
                            if (!ctrl_q[ppc_pkg::BIT_LATCH])            // [RULE_04]
                                ctrl_d[ppc_pkg::BIT_PGM] = 1'b0;        // [RULE_18]
                        end
                        ppc_pkg::OFF_CONFIG: config_d = {7'h00, wb[ppc_pkg::BIT_PRESENT]};
                        ppc_pkg::OFF_INDEX_X: ixReg_d = avs_writedata[15:0];
                        ppc_pkg::OFF_INDEX_Y: iyReg_d = avs_writedata[15:0];
                        default: ;
                    endcase
                end
            end else if (avs_read) begin
                if (inWin) begin
                    // Array reads are blocked while latches own the bus
                    if (!ctrl_q[ppc_pkg::BIT_LATCH] &&
                        config_q[ppc_pkg::BIT_PRESENT])                 // [RULE_03]
                        rdData_d = {24'h0, mem[arrayIndex({8'h00,
                                    avs_address & ~ppc_pkg::WIN_MASK})]};
                end else begin
                    case (avs_address)
                        ppc_pkg::OFF_CTRL:   rdData_d = {24'h0, ctrl_q};  // [RULE_09]
                        ppc_pkg::OFF_CONFIG: rdData_d = {24'h0, config_q};
                        ppc_pkg::OFF_STATUS: rdData_d = {27'h0, txBusy, specialMode,
                                                         (dl_q != DL_IDLE),
                                                         programPowerOn,
                                                         ctrl_q[ppc_pkg::BIT_LATCH]};
                        ppc_pkg::OFF_INDEX_X:   rdData_d = {16'h0, ixReg_q};
                        ppc_pkg::OFF_INDEX_Y:   rdData_d = {16'h0, iyReg_q};
                        ppc_pkg::OFF_LAST_ADDR: rdData_d = {20'h0, latAddr_q};
                        ppc_pkg::OFF_LAST_DATA: rdData_d = {24'h0, latData_q};
                        default:                rdData_d = 32'h0000_0000;
                    endcase
                end
            end
        end
        // Power on with latch set burns the latched byte (OTP: bits only clear)
        if (ctrl_q[ppc_pkg::BIT_PGM] && ctrl_q[ppc_pkg::BIT_LATCH]) begin  // [RULE_05]
            memWe = 1'b1;
        end
        if (dl_q == DL_PROG && usTick && usLeft_q == 16'h0000) begin
            memWe = 1'b1;
            memWa = arrayIndex(dlAddr_q);
            memWd = rxShift_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_q    <= ppc_pkg::CTRL_RESET;                           // [RULE_01]
            config_q  <= ppc_pkg::CONFIG_RESET;
            ixReg_q   <= ppc_pkg::IX_DEFAULT;
            iyReg_q   <= ppc_pkg::IY_DEFAULT;                           // [RULE_13]
            latAddr_q <= '0;
            latData_q <= ppc_pkg::ERASED_BYTE;
            rdData_q  <= 32'h0000_0000;
            ack_q     <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            config_q  <= config_d;
            ixReg_q   <= ixReg_d;
            iyReg_q   <= iyReg_d;
            latAddr_q <= latAddr_d;
            latData_q <= latData_d;
            rdData_q  <= rdData_d;
            ack_q     <= ack_d;
        end
    end

    // Array storage; no reset so it maps to RAM, erased contents preset
    initial begin
        for (int i = 0; i < ppc_pkg::ARRAY_DEPTH; i++) mem[i] = ppc_pkg::ERASED_BYTE; // [RULE_17]
    end
    always_ff @(posedge core_clk) begin
        if (memWe) mem[memWa] <= mem[memWa] & memWd;
    end

    assign avs_readdata    = rdData_q;
    assign avs_waitrequest = !ack_q;
    assign programPowerOn  = ctrl_q[ppc_pkg::BIT_PGM] && ctrl_q[ppc_pkg::BIT_LATCH]; // [RULE_05]

    // =====================================================
    // Serial receiver (8N1)
    // =====================================================
    // Mid-bit sampling; no framing error report, bad stops are dropped
    always_comb begin
        rx_d      = rx_q;
        rxShift_d = rxShift_q;
        rxBits_d  = rxBits_q;
        rxBaud_d  = rxBaud_q;
        rxByte    = '0;
        case (rx_q)
            RX_IDLE: if (!rxSync_q) begin
                rx_d     = RX_SHIFT;
                rxBaud_d = 12'(ppc_pkg::BAUD_CYCLES / 2);
                rxBits_d = 4'h0;
            end
            RX_SHIFT: if (rxBaud_q == 12'h000) begin
                rxBaud_d = 12'(ppc_pkg::BAUD_CYCLES - 1);
                rxBits_d = rxBits_q + 4'h1;
                if (rxBits_q >= 4'h1 && rxBits_q <= 4'h8)
                    rxShift_d = {rxSync_q, rxShift_q[7:1]};
                if (rxBits_q == 4'h9) begin
                    rx_d         = RX_IDLE;
                    rxByte.valid = rxSync_q;
                    rxByte.data  = rxShift_q;
                end
            end else begin
                rxBaud_d = rxBaud_q - 12'h001;
            end
            default: rx_d = RX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_q      <= RX_IDLE;
            rxShift_q <= 8'h00;
            rxBits_q  <= 4'h0;
            rxBaud_q  <= 12'h000;
        end else begin
            rx_q      <= rx_d;
            rxShift_q <= rxShift_d;
            rxBits_q  <= rxBits_d;
            rxBaud_q  <= rxBaud_d;
        end
    end

    // =====================================================
    // Serial transmitter (8N1)
    // =====================================================
    always_comb begin
        tx_d      = tx_q;
        txShift_d = txShift_q;
        txBits_d  = txBits_q;
        txBaud_d  = txBaud_q;
        case (tx_q)
            TX_IDLE: if (txReq.valid) begin
                tx_d      = TX_SHIFT;
                txShift_d = {1'b1, txReq.data, 1'b0};
                txBits_d  = 4'h0;
                txBaud_d  = 12'(ppc_pkg::BAUD_CYCLES - 1);
            end
            TX_SHIFT: if (txBaud_q == 12'h000) begin
                txBaud_d  = 12'(ppc_pkg::BAUD_CYCLES - 1);
                txShift_d = {1'b1, txShift_q[9:1]};
                txBits_d  = txBits_q + 4'h1;
                if (txBits_q == 4'h9) tx_d = TX_IDLE;
            end else begin
                txBaud_d = txBaud_q - 12'h001;
            end
            default: tx_d = TX_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_q      <= TX_IDLE;
            txShift_q <= 10'h3ff;
            txBits_q  <= 4'h0;
            txBaud_q  <= 12'h000;
        end else begin
            tx_q      <= tx_d;
            txShift_q <= txShift_d;
            txBits_q  <= txBits_d;
            txBaud_q  <= txBaud_d;
        end
    end

    assign serialTxPin = txShift_q[0];

    // =====================================================
    // Download engine
    // =====================================================
    // Started by a write to the download command register, standing in for
    // the host's jump to the utility entry; session ends only at reset
    always_comb begin
        dl_d     = dl_q;
        dlAddr_d = dlAddr_q;
        usLeft_d = usLeft_q;
        usDiv_d  = usTick ? 6'h00 : usDiv_q + 6'h01;
        txReq    = '0;
        case (dl_q)
            DL_IDLE: if (avs_write && ack_q && avs_address == ppc_pkg::OFF_DL_CMD &&
                         avs_writedata[15:0] == ppc_pkg::UTILITY_ENTRY &&
                         specialMode) begin                             // [RULE_11]
                dl_d     = DL_READY;
                dlAddr_d = iyReg_q;                                     // [RULE_13]
            end
            DL_READY: if (!txBusy) begin
                txReq = '{valid: 1'b1, data: ppc_pkg::READY_BYTE};      // [RULE_14]
                dl_d  = DL_WAIT;
            end
            DL_WAIT: if (rxByte.valid) begin
                dl_d     = DL_PROG;
                usLeft_d = ixReg_q;                                     // [RULE_13]
            end
            DL_PROG: if (usTick) begin
                if (usLeft_q == 16'h0000) dl_d = DL_ECHO;
                else usLeft_d = usLeft_q - 16'h0001;
            end
            DL_ECHO: if (!txBusy) begin
                txReq    = '{valid: 1'b1, data: mem[arrayIndex(dlAddr_q)]}; // [RULE_15]
                dlAddr_d = dlAddr_q + 16'h0001;
                dl_d     = DL_WAIT;
            end
            default: dl_d = DL_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            dl_q     <= DL_IDLE;                                        // [RULE_16]
            dlAddr_q <= ppc_pkg::IY_DEFAULT;
            usLeft_q <= 16'h0000;
            usDiv_q  <= 6'h00;
        end else begin
            dl_q     <= dl_d;
            dlAddr_q <= dlAddr_d;
            usLeft_q <= usLeft_d;
            usDiv_q  <= usDiv_d;
        end
    end

endmodule

// ==== common/ppc_pkg.sv ====
// Purpose: Shared constants and carriers for the PROM programming control block
// Assumes: 40 MHz core clock, Avalon-MM slave with 32-bit data words
// Notes:   Register offsets here are byte addresses on the slave port
package ppc_pkg;

    // =====================================================
    // Register map (byte addresses)
    // =====================================================
    localparam logic [7:0] OFF_CTRL      = 8'h00; // Programming control register
    localparam logic [7:0] OFF_CONFIG    = 8'h04; // Memory-present flag
    localparam logic [7:0] OFF_STATUS    = 8'h08; // Engine and link status
    localparam logic [7:0] OFF_INDEX_X   = 8'h0c; // Per-byte programming delay (us)
    localparam logic [7:0] OFF_INDEX_Y   = 8'h10; // Download start address
    localparam logic [7:0] OFF_DL_CMD    = 8'h14; // Download start command
    localparam logic [7:0] OFF_LAST_ADDR = 8'h18; // Latched address
    localparam logic [7:0] OFF_LAST_DATA = 8'h1c; // Latched data
    localparam logic [7:0] OFF_WIN_LO    = 8'h80; // Start of memory window
    localparam logic [7:0] WIN_MASK      = 8'h80; // Bit that selects the memory window

    // =====================================================
    // Control register fields
    // =====================================================
    localparam int BIT_PGM    = 0;
    localparam int BIT_EXTRA_ROW_TEST  = 3;
    localparam int BIT_EXTRA_COLUMN_TEST  = 4;
    localparam int BIT_LATCH  = 5;
    localparam int BIT_MBE    = 7;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] CTRL_IMPL    = 8'hb9; // Bits 6, 2, 1 absent
    localparam logic [7:0] CONFIG_RESET = 8'h01; // Memory present out of reset
    localparam int BIT_PRESENT = 0;

    // =====================================================
    // Array and download constants
    // =====================================================
    localparam int          ARRAY_AW      = 12;
    localparam int          ARRAY_DEPTH   = 4096;
    localparam logic [7:0]  ERASED_BYTE   = 8'hff;
    localparam logic [7:0]  READY_BYTE    = 8'hff;
    localparam logic [15:0] IY_DEFAULT    = 16'hf000;
    localparam logic [15:0] IX_DEFAULT    = 16'h0bb8; // 3000 us default delay
    localparam logic [15:0] UTILITY_ENTRY = 16'hbf00;

    // =====================================================
    // Timing
    // =====================================================
    localparam int CLK_MHZ        = 40;
    localparam int US_TICK_CYCLES = CLK_MHZ; // Cycles in one microsecond
    localparam int BAUD_NS        = 8680;    // One serial bit at 115200 baud
    localparam int BAUD_CYCLES    = (BAUD_NS * CLK_MHZ) / 1000;

    // Byte lane carrier for the serial link
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ppc_byte_t;

    typedef enum logic [1:0] {
        MODE_NORMAL_SINGLE,
        MODE_NORMAL_EXPANDED,
        MODE_SPECIAL_BOOT,
        MODE_SPECIAL_TEST
    } ppc_mode_t;

endpackage

// ==== tb/ppc_monitor.sv ====
// Purpose: Port checker for the PROM programming control block
// Assumes: One core_clk domain, synchronous active-high reset
// Notes:   Attached by the bind after the module
`timescale 1ns/1ps

module ppc_monitor (
    // Clock and reset
    input wire logic               core_clk,
    input wire logic               reset,
    // Register bus
    input wire logic [7:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_writedata,
    input wire logic [3:0]         avs_byteenable,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    // Mode, serial link and supply
    input wire ppc_pkg::ppc_mode_t deviceMode,
    input wire logic               serialRxPin,
    input wire logic               serialTxPin,
    input wire logic               programPowerOn
);
    // ==========================================
    // Decodes of accepted accesses
    default clocking cb @(posedge core_clk); endclocking
    logic ctrlWrite;
    logic answer;
    assign answer = !avs_waitrequest;
    assign ctrlWrite = avs_write && answer && avs_address == ppc_pkg::OFF_CTRL &&
        avs_byteenable[0];

    // ==========================================
    // Properties
    sequence s_taken; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_answer; answer ##1 avs_waitrequest; endsequence
    property p_reset_state; reset |=> !programPowerOn && serialTxPin && avs_waitrequest; endproperty
    property p_answer; disable iff (reset) s_taken |=> s_answer; endproperty
    property p_ctrl_zero; disable iff (reset) avs_read && answer &&
        avs_address == ppc_pkg::OFF_CTRL |-> avs_readdata[6] == 1'b0 && avs_readdata[2:1] == 2'h0;
    endproperty
    property p_power_cause; disable iff (reset)
        $rose(programPowerOn) |-> $past(ctrlWrite && avs_writedata[0] && avs_writedata[5]);
    endproperty
    property p_power_off; disable iff (reset)
        ctrlWrite && !(avs_writedata[0] && avs_writedata[5]) |=> !programPowerOn;
    endproperty
    property p_power_hold; disable iff (reset) !ctrlWrite |=> $stable(programPowerOn); endproperty
    property p_latched_read; disable iff (reset)
        avs_read && answer && avs_address[7] && programPowerOn |-> avs_readdata == 32'h0;
    endproperty
    property p_tx_special; disable iff (reset) $fell(serialTxPin) |->
        deviceMode inside {ppc_pkg::MODE_SPECIAL_BOOT, ppc_pkg::MODE_SPECIAL_TEST};
    endproperty

    // ==========================================
    // Assertions
    a_reset_state: assert property (p_reset_state)
        else $error("outputs not cleared by reset");
    a_answer: assert property (p_answer)
        else $error("bus answer not one cycle");
    a_ctrl_zero: assert property (p_ctrl_zero)
        else $error("absent control bits read nonzero");
    a_power_cause: assert property (p_power_cause)
        else $error("power rose without control write");
    a_power_off: assert property (p_power_off)
        else $error("power stayed on after clear");
    a_power_hold: assert property (p_power_hold)
        else $error("power changed without write");
    a_latched_read: assert property (p_latched_read)
        else $error("array readable while latched");
    a_tx_special: assert property (p_tx_special)
        else $error("link active outside special modes");
endmodule

bind ppc_prom_program_control ppc_monitor u_mon (.core_clk(core_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .deviceMode(deviceMode), .serialRxPin(serialRxPin), .serialTxPin(serialTxPin),
    .programPowerOn(programPowerOn));

// ==== tb/ppc_host_model.sv ====
// Purpose: Serial host that downloads bytes and collects echoes
// Assumes: 8N1 framing at the package bit time, line idle high
// Notes:   Sending is commanded by the bench through sendByte
`timescale 1ns/1ps

module ppc_host_model (
    // Clock
    input wire logic core_clk,
    // Serial pins
    input wire logic serialTxPin,
    output logic     serialRxPin
);
    localparam int BITC = ppc_pkg::BAUD_CYCLES;
    logic [7:0] rxQueue[$];
    logic [7:0] shiftIn;

    initial serialRxPin = 1'b1;

    // ==========================================
    // Receiver: samples mid-bit, LSB first
    always begin
        @(negedge serialTxPin);
        repeat (BITC / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BITC) @(posedge core_clk);
            shiftIn[i] = serialTxPin;
        end
        repeat (BITC) @(posedge core_clk);
        rxQueue.push_back(shiftIn);
    end

    // Transmitter: gap lets a scenario act as a slow host
    task sendByte(input logic [7:0] b, input int gap);
        repeat (gap) @(posedge core_clk);
        serialRxPin <= 1'b0;
        repeat (BITC) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            serialRxPin <= b[i];
            repeat (BITC) @(posedge core_clk);
        end
        serialRxPin <= 1'b1;
        repeat (BITC) @(posedge core_clk);
    endtask
endmodule

// ==== tb/testbench.sv ====
// Purpose: Register and download scenarios for the programming control block
// Assumes: 40 MHz clock, host model on the serial pins
// Notes:   Power hold is shortened; the array burns every powered cycle
`timescale 1ns/1ps

module testbench;
    logic               core_clk, reset, avs_read, avs_write, avs_waitrequest;
    logic [7:0]         avs_address, echo;
    logic [31:0]        avs_writedata, avs_readdata, rd;
    logic [3:0]         avs_byteenable;
    ppc_pkg::ppc_mode_t deviceMode;
    logic               serialRxPin, serialTxPin, programPowerOn;
    int                 badCount, testsRun;

    ppc_prom_program_control dut (.core_clk(core_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .deviceMode(deviceMode), .serialRxPin(serialRxPin), .serialTxPin(serialTxPin),
        .programPowerOn(programPowerOn));
    ppc_host_model host (.core_clk(core_clk), .serialTxPin(serialTxPin),
        .serialRxPin(serialRxPin));

    // ==========================================
    // Clock and helpers
    always #12.5 core_clk = ~core_clk;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            badCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task finalReport;
        $display("Checks %0d, mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // One bus cycle; request holds until waitrequest is low at a rising edge
    task access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task rdChk(input logic [7:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Bounded wait for a byte from the device
    task getByte(output logic [7:0] b);
        int n;
        n = 0;
        while (host.rxQueue.size() == 0 && n < 8000) begin @(posedge core_clk); n++; end
        b = (host.rxQueue.size() == 0) ? 8'h00 : host.rxQueue.pop_front();
    endtask

    // ==========================================
    // Watchdog, sized well above the ~20k cycles the tests need
    initial begin
        repeat (60000) @(posedge core_clk);
        badCount++;
        finalReport();
    end

    // ==========================================
    // Main sequence
    initial begin
        core_clk = 1'b0; reset = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
        avs_address = 8'h00; avs_writedata = 32'h0; avs_byteenable = 4'hf;
        deviceMode = ppc_pkg::MODE_NORMAL_SINGLE; badCount = 0; testsRun = 0;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        rdChk(ppc_pkg::OFF_CTRL, 32'h0);
        rdChk(ppc_pkg::OFF_CONFIG, 32'h1);
        rdChk(ppc_pkg::OFF_INDEX_X, {16'h0, ppc_pkg::IX_DEFAULT});
        rdChk(ppc_pkg::OFF_INDEX_Y, {16'h0, ppc_pkg::IY_DEFAULT});
        rdChk(8'h20, 32'h0); // Unmapped space reads zero
        rdChk(8'h90, 32'hff);
        access(1'b1, ppc_pkg::OFF_CTRL, 32'h01);
        rdChk(ppc_pkg::OFF_CTRL, 32'h0);
        access(1'b1, ppc_pkg::OFF_CTRL, 32'hff);
        rdChk(ppc_pkg::OFF_CTRL, 32'hb8);
        access(1'b1, ppc_pkg::OFF_CTRL, 32'h0);
        access(1'b1, ppc_pkg::OFF_CTRL, 32'h20);
        access(1'b1, 8'h90, 32'h5a);
        rdChk(ppc_pkg::OFF_LAST_DATA, 32'h5a);
        access(1'b1, ppc_pkg::OFF_CTRL, 32'h21);
        rdChk(8'h90, 32'h0);
        check({31'h0, programPowerOn}, 32'h1);
        repeat (200) @(posedge core_clk);
        access(1'b1, ppc_pkg::OFF_CTRL, 32'h0);
        rdChk(8'h90, 32'h5a);
        check({31'h0, programPowerOn}, 32'h0);
        access(1'b1, 8'h90, 32'h0);
        rdChk(8'h90, 32'h5a);
        // Download start must be refused in a normal mode
        access(1'b1, ppc_pkg::OFF_DL_CMD, {16'h0, ppc_pkg::UTILITY_ENTRY});
        repeat (2000) @(posedge core_clk);
        check(32'(host.rxQueue.size()), 32'h0);
        deviceMode <= ppc_pkg::MODE_SPECIAL_BOOT;
        access(1'b1, ppc_pkg::OFF_INDEX_X, 32'h2);
        access(1'b1, ppc_pkg::OFF_INDEX_Y, 32'hf002);
        access(1'b1, ppc_pkg::OFF_DL_CMD, {16'h0, ppc_pkg::UTILITY_ENTRY});
        getByte(echo);
        check({24'h0, echo}, {24'h0, ppc_pkg::READY_BYTE});
        host.sendByte(8'ha5, 0);
        getByte(echo);
        check({24'h0, echo}, 32'ha5);
        host.sendByte(8'h3c, 300);
        getByte(echo);
        check({24'h0, echo}, 32'h3c);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        deviceMode <= ppc_pkg::MODE_SPECIAL_TEST;
        rdChk(ppc_pkg::OFF_STATUS, 32'h8);
        rdChk(8'h82, 32'ha5);
        rdChk(8'h83, 32'h3c);
        rdChk(8'h81, 32'hff);
        finalReport();
    end
endmodule
